// File: bench/pdr_link_sva.sv
`timescale 1ns/1ns
`default_nettype none
module pdr_link_sva (
    input wire logic aclk,        // clock
    input wire logic aresetn,     // sync reset, low
    input wire logic scl,         // serial clock
    input wire logic sda_host_o,  // controller data out
    input wire logic sda_host_oe, // controller pulls low
    input wire logic sda_dev_o,   // device data out
    input wire logic sda_dev_oe,  // device pulls low
    input wire logic reset_pin_n, // reset pin
    input wire logic sda          // resolved data line
);
    localparam int PIN_LOW_CYCLES = 234;
    logic [9:0] pin_low_cnt;
    logic [9:0] scl_low_cnt;

    // length of the current low phase of pin and clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_low_cnt <= 10'h000;
            scl_low_cnt <= 10'h000;
        end else begin
            pin_low_cnt <= reset_pin_n ? 10'h000 : pin_low_cnt + 10'h001;
            scl_low_cnt <= scl ? 10'h000 : scl_low_cnt + 10'h001;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence ack_begin;
        $rose(sda_dev_oe);
    endsequence
    sequence start_seen;
        $fell(sda) && scl;
    endsequence
    property ack_span;
        ack_begin |-> (sda_dev_oe throughout ##300 1'b1) ##[1:20] !sda_dev_oe;
    endproperty

    chk_open_drain_low: assert property (!sda_host_o && !sda_dev_o)
        else $error("data line driven high by a party");
    chk_pin_low_len: assert property ($rose(reset_pin_n) |-> pin_low_cnt == PIN_LOW_CYCLES)
        else $error("reset pin pulse has wrong length");
    chk_pin_release: assert property ($fell(reset_pin_n) |-> ##[200:240] reset_pin_n)
        else $error("reset pin not released in time");
    chk_pin_bus_idle: assert property (!reset_pin_n |-> scl && !sda_host_oe && !sda_dev_oe)
        else $error("serial traffic during reset pin pulse");
    chk_ack_edge_low: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("device changed data while clock high");
    chk_ack_span_len: assert property (ack_span)
        else $error("acknowledge slot has wrong length");
    chk_start_then_clk: assert property (start_seen |-> ##[1:400] !scl)
        else $error("clock did not follow start");
    chk_scl_low_bound: assert property (!scl |-> scl_low_cnt < 10'h190)
        else $error("serial clock stuck low");
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pdr_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  dac_select = 8'h00;
    logic [7:0]  adc_select = 8'h00;
    logic        temp_read_req = 1'b0;
    logic [7:0]  dac_drive_en, dac_sleep;
    logic        ref_on, adc_on, io_default;
    logic [15:0] pd_value;
    logic [31:0] rd;
    int          miscompares = 0;
    int          checked = 0;
    int          pulses = 0;

    always #4 aclk = ~aclk;
    always @(posedge aclk) if (io_default === 1'b1) pulses++;

    pdr_link_if link ();
    pd_reset_controller #(.RESET_WAIT(50), .EXT_REF(1'b0)) u_pd_reset_controller (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
    pd_reset_device u_pd_reset_device (
        .aclk(aclk), .aresetn(aresetn), .link(link), .dac_select(dac_select), .adc_select(adc_select),
        .temp_read_req(temp_read_req), .dac_drive_en(dac_drive_en), .dac_sleep(dac_sleep),
        .ref_on(ref_on), .adc_on(adc_on), .io_default(io_default), .pd_value(pd_value));
    pdr_link_sva u_chk (
        .aclk(aclk), .aresetn(aresetn), .scl(link.scl), .sda_host_o(link.sda_host_o),
        .sda_host_oe(link.sda_host_oe), .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe),
        .reset_pin_n(link.reset_pin_n), .sda(link.sda));

    task automatic final_report;
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic hang;
        miscompares++;
        final_report();
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int          n;
        logic [1:0]  resp;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            resp = bresp;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        if (n == 100) hang();
        chk("bresp", {30'h0, resp}, {30'h0, er});
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        int          n;
        logic [1:0]  resp;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            d = rdata;
            resp = rresp;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        if (n == 100) hang();
        chk("rresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    endtask

    // poll status until the controller is idle again
    task automatic wait_idle;
        int n;
        rd = 32'h1;
        for (n = 0; n < 6000 && rd[0] !== 1'b0; n++) axi_rd(REG_STATUS, rd);
        if (rd[0] !== 1'b0) hang();
        chk("status", rd, 32'h0);
    endtask

    task automatic send(input logic [7:0] p, input logic [15:0] v);
        axi_wr(REG_POINTER, {24'h0, p}, RESP_OKAY);
        axi_wr(REG_DATA, {16'h0, v}, RESP_OKAY);
        axi_wr(REG_CMD, 32'h1, RESP_OKAY);
        wait_idle();
    endtask

    task automatic pins(input logic [7:0] ds, input logic [7:0] as, input logic t);
        @(posedge aclk);
        dac_select <= ds;
        adc_select <= as;
        temp_read_req <= t;
        repeat (3) @(posedge aclk);
    endtask

    task automatic outs(input logic [15:0] pd, input logic [7:0] sl, input logic [7:0] dr,
                        input logic r, input logic ad);
        chk("pd_value", {16'h0, pd_value}, {16'h0, pd});
        chk("dac_sleep", {24'h0, dac_sleep}, {24'h0, sl});
        chk("dac_drive_en", {24'h0, dac_drive_en}, {24'h0, dr});
        chk("ref_on", {31'h0, ref_on}, {31'h0, r});
        chk("adc_on", {31'h0, adc_on}, {31'h0, ad});
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        pins(8'hFF, 8'h00, 1'b0);
        outs(16'h0000, 8'h00, 8'hFF, 1'b0, 1'b0);
        axi_rd(REG_CMD, rd);
        chk("cmd", rd, 32'h0);
        axi_wr(REG_STATUS, 32'h1, RESP_SLVERR);
        send(PTR_POWER_DOWN, 16'hF9A5);
        outs(16'h00A5, 8'hA5, 8'h5A, 1'b0, 1'b0);
        axi_rd(REG_DATA, rd);
        chk("data", rd, 32'h0000F9A5);
        axi_rd(REG_POINTER, rd);
        chk("pointer", rd, 32'h0000000B);
        pins(8'h0F, 8'h00, 1'b0);
        outs(16'h00A5, 8'h05, 8'h0A, 1'b0, 1'b0);
        pins(8'hFF, 8'h00, 1'b0);
        send(PTR_POWER_DOWN, 16'h0200);
        outs(16'h0200, 8'h00, 8'hFF, 1'b1, 1'b0);
        pins(8'hFF, 8'h00, 1'b1);
        outs(16'h0200, 8'h00, 8'hFF, 1'b1, 1'b1);
        pins(8'hFF, 8'h10, 1'b1);
        send(PTR_POWER_DOWN, 16'h0601);
        outs(16'h0601, 8'hFF, 8'h00, 1'b0, 1'b0);
        pins(8'hFF, 8'h10, 1'b0);
        send(PTR_RESET, 16'h0DAD);
        outs(16'h0601, 8'hFF, 8'h00, 1'b0, 1'b0);
        chk("io_default", pulses, 32'h0);
        send(PTR_RESET, RESET_KEY);
        outs(16'h0000, 8'h00, 8'hFF, 1'b0, 1'b1);
        chk("io_default", pulses, 32'h1);
        send(PTR_POWER_DOWN, 16'h0001);
        outs(16'h0001, 8'h01, 8'hFE, 1'b0, 1'b1);
        axi_wr(REG_CMD, 32'h2, RESP_OKAY);
        wait_idle();
        outs(16'h0000, 8'h00, 8'hFF, 1'b0, 1'b1);
        chk("io_default", pulses, 32'h2);
        final_report();
    end
endmodule
`default_nettype wire

// File: rtl/pd_reset_controller.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module pd_reset_controller #(
    parameter int unsigned RESET_WAIT = pdr_pkg::RESET_WAIT_CYCLES, // post-reset quiet time
    parameter bit          EXT_REF    = 1'b0                       // external reference fitted
) (
    input  wire logic                      aclk,          // clock
    input  wire logic                      aresetn,       // sync reset, low
    input  wire logic [pdr_pkg::AXI_AW-1:0] s_axi_awaddr, // write address
    input  wire logic                      s_axi_awvalid, // write address valid
    output var  logic                      s_axi_awready, // write address ready
    input  wire logic [31:0]               s_axi_wdata,   // write data
    input  wire logic [3:0]                s_axi_wstrb,   // write strobes
    input  wire logic                      s_axi_wvalid,  // write data valid
    output var  logic                      s_axi_wready,  // write data ready
    output var  logic [1:0]                s_axi_bresp,   // write response
    output var  logic                      s_axi_bvalid,  // write response valid
    input  wire logic                      s_axi_bready,  // write response ready
    input  wire logic [pdr_pkg::AXI_AW-1:0] s_axi_araddr, // read address
    input  wire logic                      s_axi_arvalid, // read address valid
    output var  logic                      s_axi_arready, // read address ready
    output var  logic [31:0]               s_axi_rdata,   // read data
    output var  logic [1:0]                s_axi_rresp,   // read response
    output var  logic                      s_axi_rvalid,  // read data valid
    input  wire logic                      s_axi_rready,  // read data ready
    pdr_link_if.host                       link           // serial link and reset pin
);
    import pdr_pkg::*;
    typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_PIN, H_WAIT} hstate_t;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_have;
        logic        w_have;
        logic [3:0]  aw_addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [7:0]  ptr;
        logic [15:0] data;
        logic        nack;
        hstate_t     st;
        logic [1:0]  q;
        logic [3:0]  bitn;
        logic [1:0]  idx;
        logic        scl;
        logic        sda_oe;
        logic        rst_n;
    } host_state_t;
    host_state_t s;
    host_state_t n;
    logic        qtick;
    logic        wait_done;
    logic [15:0] tx_data;
    logic [7:0]  frame;
    logic        is_rst;

    tick_timer #(.CYCLES(QUARTER_CYCLES)) quarter_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (s.st != H_IDLE && s.st != H_WAIT),
        .done    (qtick)
    );

    tick_timer #(.CYCLES(RESET_WAIT)) quiet_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (s.st == H_WAIT),
        .done    (wait_done)
    );

    always_comb begin
        n = s;
        tx_data = s.data;
        if (s.ptr == PTR_POWER_DOWN) begin
            tx_data = s.data & PD_WRITABLE_MASK;
            if (EXT_REF) begin
                tx_data[REF_EN_BIT] = 1'b0;
            end
        end
        is_rst = (s.ptr == PTR_RESET) && (s.data == RESET_KEY);
        unique case (s.idx)
            2'd0: frame = {DEV_ADDR, 1'b0};
            2'd1: frame = s.ptr;
            2'd2: frame = tx_data[15:8];
            2'd3: frame = tx_data[7:0];
        endcase

        // register bus: write side
        if (s_axi_awvalid && s.awready) begin
            n.aw_have = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_have = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_have && s.w_have && !s.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            unique case ({s.aw_addr[3:2], 2'b00})
                REG_POINTER: if (s.wstrb[0]) n.ptr = s.wdata[7:0];
                REG_DATA: begin
                    if (s.wstrb[0]) n.data[7:0] = s.wdata[7:0];
                    if (s.wstrb[1]) n.data[15:8] = s.wdata[15:8];
                end
                REG_CMD: begin
                    if (s.st == H_IDLE && s.wstrb[0]) begin
                        if (s.wdata[CMD_SEND_BIT]) begin
                            n.st = H_START;
                            n.nack = 1'b0;
                        end else if (s.wdata[CMD_PIN_BIT]) begin
                            n.st = H_PIN;
                        end
                    end
                end
                default: n.bresp = RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready = !n.w_have && !n.bvalid;

        // register bus: read side
        if (s_axi_arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = 32'h0000_0000;
            unique case ({s_axi_araddr[3:2], 2'b00})
                REG_POINTER: n.rdata[7:0] = s.ptr;
                REG_DATA: n.rdata[15:0] = s.data;
                REG_CMD: n.rdata = 32'h0000_0000;
                REG_STATUS: n.rdata[1:0] = {s.nack, s.st != H_IDLE};
                default: n.rresp = RESP_SLVERR;
            endcase
        end else if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        n.arready = !n.rvalid;

        // link engine, four quarter ticks per bit
        if (s.st == H_IDLE) begin
            n.q = 2'd0;
            n.bitn = 4'h0;
            n.idx = 2'd0;
        end
        if (s.st == H_WAIT && wait_done) begin
            n.st = H_IDLE;
        end
        if (qtick) begin
            n.q = s.q + 2'd1;
            unique case (s.st)
                H_START: begin
                    unique case (s.q)
                        2'd0: begin
                            n.scl = 1'b1;
                            n.sda_oe = 1'b0;
                        end
                        2'd1: n.sda_oe = 1'b1;
                        2'd2: n.scl = 1'b0;
                        2'd3: n.st = H_BIT;
                    endcase
                end
                H_BIT: begin
                    unique case (s.q)
                        2'd0: n.sda_oe = (s.bitn < 4'h8) ? !frame[3'd7 - s.bitn[2:0]] : 1'b0;
                        2'd1: n.scl = 1'b1;
                        2'd2: begin
                            if (s.bitn == 4'h8 && link.sda && !(is_rst && s.idx == 2'd3)) begin
                                n.nack = 1'b1;
                            end
                        end
                        2'd3: begin
                            n.scl = 1'b0;
                            if (s.bitn == 4'h8) begin
                                n.bitn = 4'h0;
                                if (s.idx == 2'd3 || s.nack) begin
                                    n.st = H_STOP;
                                end else begin
                                    n.idx = s.idx + 2'd1;
                                end
                            end else begin
                                n.bitn = s.bitn + 4'h1;
                            end
                        end
                    endcase
                end
                H_STOP: begin
                    unique case (s.q)
                        2'd0: n.sda_oe = 1'b1;
                        2'd1: n.scl = 1'b1;
                        2'd2: n.sda_oe = 1'b0;
                        2'd3: n.st = (is_rst && !s.nack) ? H_WAIT : H_IDLE;
                    endcase
                end
                H_PIN: begin
                    if (s.q == 2'd0) begin
                        n.rst_n = 1'b0;
                    end else if (s.q == 2'd3) begin
                        n.rst_n = 1'b1;
                        n.st = H_WAIT;
                    end
                end
                default: n.st = s.st;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.scl <= 1'b1;
            s.rst_n <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign link.scl = s.scl;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe = s.sda_oe;
    assign link.reset_pin_n = s.rst_n;
endmodule
`default_nettype wire

// File: rtl/pd_reset_device.sv
`timescale 1ns/1ns
`default_nettype none
module pd_reset_device (
    input  wire logic       aclk,          // clock
    input  wire logic       aresetn,       // sync reset, low
    pdr_link_if.dev         link,          // serial link and reset pin
    input  wire logic [7:0] dac_select,    // pins configured as DAC
    input  wire logic [7:0] adc_select,    // pins configured as ADC
    input  wire logic       temp_read_req, // temperature read under way
    output var  logic [7:0] dac_drive_en,  // DAC output driven
    output var  logic [7:0] dac_sleep,     // DAC channel powered down
    output var  logic       ref_on,        // internal reference on
    output var  logic       adc_on,        // ADC powered
    output var  logic       io_default,    // pulse: pins to pull-down
    output var  logic [15:0] pd_value      // power-down register
);
    import pdr_pkg::*;
    typedef enum logic [2:0] {D_IDLE, D_ADDR, D_PTR, D_MSB, D_LSB, D_SKIP} dphase_t;
    typedef struct packed {
        logic        scl_q;
        logic        sda_q;
        logic        rst_q;
        dphase_t     ph;
        logic [3:0]  bits;
        logic [7:0]  sh;
        logic [7:0]  ptr;
        logic [7:0]  msb;
        logic [15:0] pd;
        logic        sda_oe;
        logic [7:0]  drive;
        logic [7:0]  sleep;
        logic        ref_on;
        logic        adc_on;
        logic        io_default;
    } dev_state_t;
    dev_state_t s;
    dev_state_t n;
    logic       do_reset;
    logic       gs;

    always_comb begin
        n = s;
        do_reset = 1'b0;
        n.scl_q = link.scl;
        n.sda_q = link.sda;
        n.rst_q = link.reset_pin_n;
        n.io_default = 1'b0;
        if (s.scl_q && link.scl && s.sda_q && !link.sda) begin
            n.ph = D_ADDR;
            n.bits = 4'h0;
            n.sda_oe = 1'b0;
        end else if (s.scl_q && link.scl && !s.sda_q && link.sda) begin
            n.ph = D_IDLE;
            n.sda_oe = 1'b0;
        end else if (s.ph != D_IDLE) begin
            if (!s.scl_q && link.scl && s.bits < 4'h8) begin
                n.sh = {s.sh[6:0], link.sda};
                n.bits = s.bits + 4'h1;
            end
            if (s.scl_q && !link.scl && s.bits == 4'h8) begin
                n.bits = 4'h9;
                unique case (s.ph)
                    D_ADDR: n.sda_oe = (s.sh == {DEV_ADDR, 1'b0});
                    D_PTR: begin
                        n.ptr = s.sh;
                        n.sda_oe = 1'b1;
                    end
                    D_MSB: begin
                        n.msb = s.sh;
                        n.sda_oe = 1'b1;
                    end
                    D_LSB: begin
                        if (s.ptr == PTR_RESET && {s.msb, s.sh} == RESET_KEY) begin
                            do_reset = 1'b1;
                        end else begin
                            n.sda_oe = 1'b1;
                            if (s.ptr == PTR_POWER_DOWN) begin
                                n.pd = {s.msb, s.sh} & PD_WRITABLE_MASK;
                            end
                        end
                    end
                    default: n.sda_oe = 1'b0;
                endcase
            end
            if (s.scl_q && !link.scl && s.bits == 4'h9) begin
                n.sda_oe = 1'b0;
                n.bits = 4'h0;
                unique case (s.ph)
                    D_ADDR: n.ph = s.sda_oe ? D_PTR : D_SKIP;
                    D_PTR: n.ph = D_MSB;
                    D_MSB: n.ph = D_LSB;
                    default: n.ph = D_SKIP;
                endcase
            end
        end
        if (s.rst_q && !link.reset_pin_n) begin
            do_reset = 1'b1;
        end
        if (do_reset) begin
            n.pd = PD_RESET;
            n.ptr = 8'h00;
            n.msb = 8'h00;
            n.ph = D_IDLE;
            n.sda_oe = 1'b0;
            n.io_default = 1'b1;
        end
        gs = n.pd[GSLEEP_BIT];
        n.sleep = gs ? 8'hFF : (n.pd[7:0] & dac_select);
        n.drive = dac_select & ~n.sleep;
        n.ref_on = !gs && n.pd[REF_EN_BIT];
        n.adc_on = !gs && ((|adc_select) || temp_read_req);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign link.sda_dev_o = 1'b0;
    assign link.sda_dev_oe = s.sda_oe;
    assign dac_drive_en = s.drive;
    assign dac_sleep = s.sleep;
    assign ref_on = s.ref_on;
    assign adc_on = s.adc_on;
    assign io_default = s.io_default;
    assign pd_value = s.pd;
endmodule
`default_nettype wire

// File: rtl/pdr_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pdr_link_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic reset_pin_n;
    wire  sda;
    // open-drain wired-and with pull-up
    assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
    modport host (output scl, output sda_host_o, output sda_host_oe, output reset_pin_n, input sda);
    modport dev (input scl, input reset_pin_n, input sda, output sda_dev_o, output sda_dev_oe);
endinterface
`default_nettype wire

// File: rtl/pdr_pkg.sv
package pdr_pkg;
    localparam logic [6:0]  DEV_ADDR         = 7'h10;
    localparam logic [7:0]  PTR_POWER_DOWN   = 8'h0B;
    localparam logic [7:0]  PTR_RESET        = 8'h0F;
    localparam logic [15:0] RESET_KEY        = 16'h0DAC;
    localparam logic [15:0] PD_RESET         = 16'h0000;
    localparam logic [15:0] PD_WRITABLE_MASK = 16'h06FF;
    localparam int          GSLEEP_BIT       = 10;
    localparam int          REF_EN_BIT       = 9;
    localparam int          CLK_PERIOD_NS    = 8;
    localparam int          SCL_PERIOD_NS    = 2500;
    localparam int          QUARTER_CYCLES   = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
    localparam int          RESET_TIME_NS    = 100000;
    localparam int          RESET_WAIT_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          AXI_AW           = 4;
    localparam logic [3:0]  REG_POINTER      = 4'h0;
    localparam logic [3:0]  REG_DATA         = 4'h4;
    localparam logic [3:0]  REG_CMD          = 4'h8;
    localparam logic [3:0]  REG_STATUS       = 4'hC;
    localparam int          CMD_SEND_BIT     = 0;
    localparam int          CMD_PIN_BIT      = 1;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

// File: rtl/tick_timer.sv
`timescale 1ns/1ns
`default_nettype none
module tick_timer #(
    parameter int unsigned CYCLES = 4
) (
    input  wire logic aclk,    // clock
    input  wire logic aresetn, // sync reset, low
    input  wire logic run,     // count while high
    output var  logic done     // pulse every CYCLES
);
    localparam int W = $clog2(CYCLES + 1);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } timer_state_t;
    timer_state_t s;
    timer_state_t n;

    always_comb begin
        n = s;
        n.done = 1'b0;
        if (!run) begin
            n.cnt = '0;
        end else if (s.cnt == W'(CYCLES - 1)) begin
            n.cnt = '0;
            n.done = 1'b1;
        end else begin
            n.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign done = s.done;
endmodule
`default_nettype wire
